// File: core/rsr_pkg.sv
// Package for the radio status register bank: register indices, field
// positions, reset values, encodings and the packed carriers.
// Assumes 32-bit AXI4-Lite data and one aligned word per register.
package rsr_pkg;

    // Printed register indices; byte address is four times the index
    localparam logic [15:0] RSR_IDX_REVISION = 16'hDF37;
    localparam logic [15:0] RSR_IDX_OFFSET = 16'hDF38;
    localparam logic [15:0] RSR_IDX_LINK_QUALITY = 16'hDF39;
    localparam logic [15:0] RSR_IDX_STRENGTH = 16'hDF3A;
    localparam logic [15:0] RSR_IDX_FSM_STATE = 16'hDF3B;
    localparam logic [15:0] RSR_IDX_PKT_STATUS = 16'hDF3C;
    localparam logic [15:0] RSR_IDX_TUNING = 16'hDF3D;
    // Control and interrupt registers of this bank
    localparam logic [15:0] RSR_IDX_THRESHOLD = 16'hDF40;
    localparam logic [15:0] RSR_IDX_CHAN_CFG = 16'hDF41;
    localparam logic [15:0] RSR_IDX_IRQ_STATUS = 16'hDF42;
    localparam logic [15:0] RSR_IDX_IRQ_MASK = 16'hDF43;

    // Field positions
    localparam int RSR_CRC_OK_BIT = 7;
    localparam int RSR_CS_BIT = 6;
    localparam int RSR_PQT_BIT = 5;
    localparam int RSR_CCA_BIT = 4;
    localparam int RSR_SFD_BIT = 3;

    // Interrupt event bits
    localparam int RSR_EV_CRC_OK = 0;
    localparam int RSR_EV_FRAME = 1;
    localparam int RSR_EV_RX_OVF = 2;
    localparam int RSR_EV_TX_UNF = 3;
    localparam int RSR_EV_LQI_DONE = 4;
    localparam int RSR_EV_COUNT = 5;

    // Reset values
    localparam logic [7:0] RSR_THRESHOLD_RESET = 8'h00;
    localparam logic [1:0] RSR_CCA_MODE_RESET = 2'h1;
    localparam logic [7:0] RSR_REVISION_DEFAULT = 8'h5A; // Arbitrary value

    // Link quality span in symbols after the sync word
    localparam int RSR_LQI_SYMBOLS = 64;

    // Radio control state codes
    localparam logic [4:0] RSR_ST_SLEEP = 5'h00;
    localparam logic [4:0] RSR_ST_IDLE = 5'h01;
    localparam logic [4:0] RSR_ST_RX = 5'h0D;
    localparam logic [4:0] RSR_ST_RX_RESTART = 5'h0F;
    localparam logic [4:0] RSR_ST_RX_OVERFLOW = 5'h11;
    localparam logic [4:0] RSR_ST_TX = 5'h13;
    localparam logic [4:0] RSR_ST_TX_UNDERFLOW = 5'h16;

    // AXI responses
    localparam logic [1:0] RSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] RSR_RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        RSR_MOD_2FSK = 3'b000,
        RSR_MOD_GFSK = 3'b001,
        RSR_MOD_OOK = 3'b011,
        RSR_MOD_4FSK = 3'b100,
        RSR_MOD_MSK = 3'b111
    } rsr_mod_type;

    typedef enum logic [1:0] {
        RSR_CCA_ALWAYS = 2'b00,
        RSR_CCA_BELOW = 2'b01,
        RSR_CCA_NO_PACKET = 2'b10,
        RSR_CCA_BOTH = 2'b11
    } rsr_cca_type;

    typedef enum logic [1:0] {
        RSR_PM_ACTIVE = 2'b00,
        RSR_PM_LIGHT = 2'b01,
        RSR_PM_DEEP_A = 2'b10,
        RSR_PM_DEEP_B = 2'b11
    } rsr_pm_type;

    // Live status from the demodulator and radio control logic
    typedef struct packed {
        logic [4:0] radio_fsm_code;
        logic [7:0] carrier_offset_field;
        logic [7:0] signal_strength_field;
        logic [7:0] oscillator_tuning_field;
        logic preamble_quality_flag;
        logic frame_start_flag;
        logic crc_done;
        logic crc_match;
        logic symbol_tick;
        logic [6:0] symbol_quality;
        rsr_mod_type modulation;
    } rsr_radio_type;

    typedef struct packed {
        logic [7:0] carrier_offset_field;
        logic [7:0] signal_strength_field;
        logic [4:0] radio_fsm_code;
        logic [7:0] oscillator_tuning_field;
        logic crc_ok;
        logic carrier_sense;
        logic preamble_quality_flag;
        logic clear_channel_flag;
        logic frame_start_flag;
        logic [7:0] threshold;
        rsr_cca_type cca_mode;
        logic [RSR_EV_COUNT-1:0] irq_status;
        logic [RSR_EV_COUNT-1:0] irq_mask;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } rsr_bank_state_type;

endpackage : rsr_pkg

// File: core/rsr_link_quality.sv
// Link quality estimator: averages per-symbol quality over a fixed span
// of symbols following the sync word.
// Assumes symbol ticks and quality come from logic on the same clock.
`timescale 1ns/1ps
module rsr_link_quality #(
    parameter int SYMBOLS = rsr_pkg::RSR_LQI_SYMBOLS
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic start_in,
    input wire logic symbol_tick_in,
    input wire logic [6:0] symbol_quality_in,
    output logic [6:0] estimate_out,
    output logic done_out
);
    import rsr_pkg::*;

    localparam int CW = $clog2(SYMBOLS);
    localparam int SW = CW + 7;
    localparam logic [CW-1:0] LAST = CW'(SYMBOLS - 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] count;
        logic [SW-1:0] sum;
        logic [6:0] estimate;
        logic done;
    } rsr_lqi_state_type;

    rsr_lqi_state_type state;
    rsr_lqi_state_type next_state;

    // Span is counted in symbols, so 2-ary and 4-ary need no distinction
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (start_in) begin
            next_state.busy = 1'b1;
            next_state.count = '0;
            next_state.sum = '0;
        end else if (state.busy && symbol_tick_in) begin
            next_state.sum = state.sum + SW'(symbol_quality_in); // R04
            next_state.count = state.count + CW'(1);
            if (state.count == LAST) begin
                next_state.busy = 1'b0;
                next_state.done = 1'b1;
                next_state.estimate =
                    7'((state.sum + SW'(symbol_quality_in)) >> CW); // R04
            end
        end
    end

    // Clock enable low freezes the accumulator
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign estimate_out = state.estimate;
    assign done_out = state.done;

endmodule : rsr_link_quality

// File: core/rsr_bank.sv
// Radio status register bank behind an AXI4-Lite slave port.
// Assumes radio status inputs are synchronous to clk_in.
//
// What this block does
// R01 - Reports an 8-bit two's complement carrier offset estimate.
// R02 - The offset estimate reads zero while on-off keying is selected.
// R03 - A checksum-match flag at bit 7 of two registers, cleared on RX entry unless a comparison completes in that cycle.
// R04 - A 7-bit link quality estimate over the 64 symbols after sync.
// R05 - The 5-bit radio state code in bits 4:0, upper bits reading zero.
// R06 - Packet flags at bits 6 to 3, low bits zero, all reset to zero.
// R07 - The 8-bit oscillator tuning value is readable for test.
// R08 - Regulator off in the two deepest modes with all contents retained.
// R09 - Clear channel is high below threshold, per the selected mode.
// R10 - Carrier sense is high while signal strength exceeds the threshold.
// R11 - The 8-bit signal strength is readable at any time.
// R12 - Writes to the status registers are ignored.
`timescale 1ns/1ps
module rsr_bank #(
    parameter int ADDR_WIDTH = 18,
    parameter logic [7:0] REVISION = rsr_pkg::RSR_REVISION_DEFAULT
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Radio side
    input rsr_pkg::rsr_radio_type radio_in,
    input rsr_pkg::rsr_pm_type power_mode_in,
    output logic regulator_on_out,
    output logic irq_out,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    // AXI4-Lite write response
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    // AXI4-Lite read data
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out
);
    import rsr_pkg::*;

    // Word-aligned compare; byte address is four times the index
    function automatic logic hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [15:0] index
    );
        hit = addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(index);
    endfunction : hit

    rsr_bank_state_type state;
    rsr_bank_state_type next_state;

    logic deep_sleep;
    logic write_fire;
    logic read_fire;
    logic frame_start_rise;
    logic lqi_start;
    logic lqi_done;
    logic [6:0] lqi_estimate;
    logic rx_entry;
    logic above_threshold;
    logic [RSR_EV_COUNT-1:0] events;
    logic [7:0] link_quality_byte;
    logic [7:0] pkt_status_byte;

    // Deep modes cut the regulator; the frozen captures model retention
    assign deep_sleep = (power_mode_in == RSR_PM_DEEP_A) ||
                        (power_mode_in == RSR_PM_DEEP_B); // R08
    assign regulator_on_out = !deep_sleep; // R08

    // Address and data are taken together; the master holds both
    assign s_axi_awready_out = s_axi_awvalid_in && s_axi_wvalid_in &&
                               !state.bvalid && ce_in;
    assign s_axi_wready_out = s_axi_awready_out;
    assign write_fire = s_axi_awready_out;
    assign s_axi_arready_out = !state.rvalid && ce_in;
    assign read_fire = s_axi_arvalid_in && s_axi_arready_out;

    // Sync found starts a new link quality span
    assign frame_start_rise = radio_in.frame_start_flag &&
                              !state.frame_start_flag;
    assign lqi_start = frame_start_rise && !deep_sleep;

    // Entering or restarting receive clears the checksum-match flag
    assign rx_entry = (radio_in.radio_fsm_code != state.radio_fsm_code) &&
                      ((radio_in.radio_fsm_code == RSR_ST_RX) ||
                       (radio_in.radio_fsm_code == RSR_ST_RX_RESTART));

    // Strength is two's complement, so compare signed
    assign above_threshold = $signed(radio_in.signal_strength_field) >
                             $signed(state.threshold);

    // Events that set sticky interrupt bits
    always_comb begin
        events = '0;
        if (!deep_sleep) begin
            events[RSR_EV_CRC_OK] = radio_in.crc_done && radio_in.crc_match;
            events[RSR_EV_FRAME] = frame_start_rise;
            events[RSR_EV_RX_OVF] =
                (radio_in.radio_fsm_code == RSR_ST_RX_OVERFLOW) &&
                (state.radio_fsm_code != RSR_ST_RX_OVERFLOW);
            events[RSR_EV_TX_UNF] =
                (radio_in.radio_fsm_code == RSR_ST_TX_UNDERFLOW) &&
                (state.radio_fsm_code != RSR_ST_TX_UNDERFLOW);
            events[RSR_EV_LQI_DONE] = lqi_done;
        end
    end

    // Read views shared by two registers
    assign link_quality_byte = {state.crc_ok, lqi_estimate}; // R03 R04
    assign pkt_status_byte = {state.crc_ok, state.carrier_sense,
                              state.preamble_quality_flag,
                              state.clear_channel_flag,
                              state.frame_start_flag, 3'b000}; // R06

    rsr_link_quality #(
        .SYMBOLS(RSR_LQI_SYMBOLS)
    ) u_link_quality (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .start_in(lqi_start),
        .symbol_tick_in(radio_in.symbol_tick && !deep_sleep),
        .symbol_quality_in(radio_in.symbol_quality),
        .estimate_out(lqi_estimate),
        .done_out(lqi_done)
    );

    // Next state: radio captures, flags, bus slave and interrupt status
    always_comb begin
        next_state = state;

        // Radio captures hold still in deep modes, so contents are kept
        if (!deep_sleep) begin
            if (radio_in.modulation == RSR_MOD_OOK) begin
                next_state.carrier_offset_field = 8'h00; // R02
            end else begin
                next_state.carrier_offset_field =
                    radio_in.carrier_offset_field; // R01
            end
            next_state.signal_strength_field =
                radio_in.signal_strength_field; // R11
            next_state.radio_fsm_code = radio_in.radio_fsm_code; // R05
            next_state.oscillator_tuning_field =
                radio_in.oscillator_tuning_field; // R07
            next_state.preamble_quality_flag =
                radio_in.preamble_quality_flag; // R06
            next_state.frame_start_flag = radio_in.frame_start_flag; // R06
            next_state.carrier_sense = above_threshold; // R10

            // Clear channel per mode
            case (state.cca_mode)
                RSR_CCA_ALWAYS: begin
                    next_state.clear_channel_flag = 1'b1;
                end
                RSR_CCA_BELOW: begin
                    next_state.clear_channel_flag = !above_threshold; // R09
                end
                RSR_CCA_NO_PACKET: begin
                    next_state.clear_channel_flag =
                        !radio_in.frame_start_flag; // R09
                end
                default: begin
                    next_state.clear_channel_flag = !above_threshold &&
                        !radio_in.frame_start_flag; // R09
                end
            endcase

            // Last comparison decides; a match in the entry cycle wins
            if (radio_in.crc_done) begin
                next_state.crc_ok = radio_in.crc_match; // R03
            end else if (rx_entry) begin
                next_state.crc_ok = 1'b0; // R03
            end
        end

        // Write response handshake
        if (state.bvalid && s_axi_bready_in) begin
            next_state.bvalid = 1'b0;
        end
        // Status registers take writes without effect
        if (write_fire) begin
            next_state.bvalid = 1'b1;
            next_state.bresp = RSR_RESP_OKAY;
            if (hit(s_axi_awaddr_in, RSR_IDX_THRESHOLD)) begin
                if (s_axi_wstrb_in[0]) begin
                    next_state.threshold = s_axi_wdata_in[7:0];
                end
            end else if (hit(s_axi_awaddr_in, RSR_IDX_CHAN_CFG)) begin
                if (s_axi_wstrb_in[0]) begin
                    next_state.cca_mode = rsr_cca_type'(s_axi_wdata_in[1:0]);
                end
            end else if (hit(s_axi_awaddr_in, RSR_IDX_IRQ_MASK)) begin
                if (s_axi_wstrb_in[0]) begin
                    next_state.irq_mask =
                        s_axi_wdata_in[RSR_EV_COUNT-1:0];
                end
            end else if (hit(s_axi_awaddr_in, RSR_IDX_REVISION) ||
                         hit(s_axi_awaddr_in, RSR_IDX_OFFSET) ||
                         hit(s_axi_awaddr_in, RSR_IDX_LINK_QUALITY) ||
                         hit(s_axi_awaddr_in, RSR_IDX_STRENGTH) ||
                         hit(s_axi_awaddr_in, RSR_IDX_FSM_STATE) ||
                         hit(s_axi_awaddr_in, RSR_IDX_PKT_STATUS) ||
                         hit(s_axi_awaddr_in, RSR_IDX_TUNING) ||
                         hit(s_axi_awaddr_in, RSR_IDX_IRQ_STATUS)) begin
                next_state.bresp = RSR_RESP_OKAY; // R12
            end else begin
                next_state.bresp = RSR_RESP_DECERR;
            end
        end

        // Read data handshake
        if (state.rvalid && s_axi_rready_in) begin
            next_state.rvalid = 1'b0;
        end
        // Read decode; read data always come from the register
        if (read_fire) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = RSR_RESP_OKAY;
            next_state.rdata = 32'h0000_0000;
            if (hit(s_axi_araddr_in, RSR_IDX_REVISION)) begin
                next_state.rdata[7:0] = REVISION;
            end else if (hit(s_axi_araddr_in, RSR_IDX_OFFSET)) begin
                next_state.rdata[7:0] = state.carrier_offset_field; // R01
            end else if (hit(s_axi_araddr_in, RSR_IDX_LINK_QUALITY)) begin
                next_state.rdata[7:0] = link_quality_byte; // R03
            end else if (hit(s_axi_araddr_in, RSR_IDX_STRENGTH)) begin
                next_state.rdata[7:0] = state.signal_strength_field; // R11
            end else if (hit(s_axi_araddr_in, RSR_IDX_FSM_STATE)) begin
                next_state.rdata[7:0] =
                    {3'b000, state.radio_fsm_code}; // R05
            end else if (hit(s_axi_araddr_in, RSR_IDX_PKT_STATUS)) begin
                next_state.rdata[7:0] = pkt_status_byte; // R06
            end else if (hit(s_axi_araddr_in, RSR_IDX_TUNING)) begin
                next_state.rdata[7:0] = state.oscillator_tuning_field; // R07
            end else if (hit(s_axi_araddr_in, RSR_IDX_THRESHOLD)) begin
                next_state.rdata[7:0] = state.threshold;
            end else if (hit(s_axi_araddr_in, RSR_IDX_CHAN_CFG)) begin
                next_state.rdata[1:0] = state.cca_mode;
            end else if (hit(s_axi_araddr_in, RSR_IDX_IRQ_STATUS)) begin
                next_state.rdata[RSR_EV_COUNT-1:0] = state.irq_status;
            end else if (hit(s_axi_araddr_in, RSR_IDX_IRQ_MASK)) begin
                next_state.rdata[RSR_EV_COUNT-1:0] = state.irq_mask;
            end else begin
                next_state.rresp = RSR_RESP_DECERR;
            end
        end

        // Read clears status; a new event in the same cycle survives
        if (read_fire && hit(s_axi_araddr_in, RSR_IDX_IRQ_STATUS)) begin
            next_state.irq_status = events;
        end else begin
            next_state.irq_status = state.irq_status | events;
        end
    end

    // Single state register; clock enable low freezes everything
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
            state.threshold <= RSR_THRESHOLD_RESET;
            state.cca_mode <= rsr_cca_type'(RSR_CCA_MODE_RESET);
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register
    assign irq_out = |(state.irq_status & state.irq_mask);
    assign s_axi_bvalid_out = state.bvalid;
    assign s_axi_bresp_out = state.bresp;
    assign s_axi_rvalid_out = state.rvalid;
    assign s_axi_rdata_out = state.rdata;
    assign s_axi_rresp_out = state.rresp;

endmodule : rsr_bank

// File: tb/rsr_bank_chk.sv
// Concurrent checks on the radio status register bank ports.
// Assumes it is bound into rsr_bank and sees only that module's ports.
`timescale 1ns/1ps
module rsr_bank_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input rsr_pkg::rsr_pm_type power_mode_in,
    input logic regulator_on_out,
    input logic irq_out,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_wvalid_in,
    input logic s_axi_awready_out,
    input logic s_axi_wready_out,
    input logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input logic s_axi_arready_out,
    input logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input logic [31:0] s_axi_rdata_out
);
    import rsr_pkg::*;
    // One clock domain, so one default clock and reset for all checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    regulator_mode_a: assert property (regulator_on_out ==
        (power_mode_in != RSR_PM_DEEP_A && power_mode_in != RSR_PM_DEEP_B))
        else $error("regulator level wrong");
    write_answer_a: assert property (s_axi_awvalid_in &&
        s_axi_wvalid_in && s_axi_awready_out |=> s_axi_bvalid_out)
        else $error("no write response");
    write_gate_a: assert property (s_axi_wready_out == s_axi_awready_out &&
        s_axi_awready_out == (s_axi_awvalid_in && s_axi_wvalid_in &&
        !s_axi_bvalid_out && ce_in))
        else $error("write ready wrong");
    bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out)
        else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid_in &&
        s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("no read data");
    rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data changed");
    read_gate_a: assert property (s_axi_arready_out ==
        (!s_axi_rvalid_out && ce_in))
        else $error("read ready wrong");
    upper_zero_a: assert property (s_axi_rvalid_out |->
        s_axi_rdata_out[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    read_clear_a: assert property (s_axi_rvalid_out && s_axi_rready_in &&
        ce_in |=> !s_axi_rvalid_out)
        else $error("read data not released");

    // Main traffic kinds seen at least once
    write_seen_c: cover property (s_axi_awready_out ##1 s_axi_bvalid_out);
    read_seen_c: cover property (s_axi_arready_out ##1 s_axi_rvalid_out);
    irq_seen_c: cover property ($rose(irq_out));
endmodule : rsr_bank_chk

bind rsr_bank rsr_bank_chk u_chk (.*);

// File: tb/tb_radio_status_register_bank.sv
// Self-checking bench for the radio status register bank.
// Assumes rsr_bank with default parameters; the bench acts as bus master.
`timescale 1ns/1ps
module tb_radio_status_register_bank;
    import rsr_pkg::*;
    localparam logic [31:0] M = 32'hFFFFFFFF;
    logic clk_in = 1'b0, rst_n_in = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid, irq, reg_on;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    rsr_radio_type radio = '0;
    rsr_pm_type pm = RSR_PM_DEEP_B;
    int fails = 0, check_count = 0;

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    fails++; $display("unexpected at %0t: got %h expected %h", $time, \
    got, exp); end end

    rsr_bank u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .radio_in(radio), .power_mode_in(pm), .regulator_on_out(reg_on),
        .irq_out(irq), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_awprot_in(3'h0), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_arprot_in(3'h0),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));

    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    // Write cycle: address and data offered together, then the response
    task automatic axi_write(input logic [15:0] idx, input logic [31:0] d,
                             input logic [1:0] er);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge clk_in); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(posedge clk_in); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask : axi_write

    // Read cycle; only the bits in msk are compared
    task automatic axi_read(input logic [15:0] idx, input logic [31:0] exp,
                            input logic [31:0] msk, input logic [1:0] er);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_in); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_in); while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHK(rdata & msk, exp)
        `CHK(rresp, er)
    endtask : axi_read

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence; deep mode during reset keeps flags at reset value
    initial begin
        tick(4);
        rst_n_in <= 1'b1;
        tick(1);
        `CHK(reg_on, 1'b0)
        axi_read(RSR_IDX_PKT_STATUS, 32'h0, M, RSR_RESP_OKAY);
        axi_read(RSR_IDX_REVISION, RSR_REVISION_DEFAULT, M, RSR_RESP_OKAY);
        axi_read(RSR_IDX_CHAN_CFG, 32'h1, M, RSR_RESP_OKAY);
        pm <= RSR_PM_ACTIVE;
        radio.signal_strength_field <= 8'h40;
        radio.carrier_offset_field <= 8'h85;
        radio.oscillator_tuning_field <= 8'h3C;
        radio.radio_fsm_code <= RSR_ST_RX;
        radio.preamble_quality_flag <= 1'b1;
        tick(2);
        axi_read(RSR_IDX_OFFSET, 32'h85, M, RSR_RESP_OKAY);
        axi_read(RSR_IDX_STRENGTH, 32'h40, M, RSR_RESP_OKAY);
        axi_read(RSR_IDX_TUNING, 32'h3C, M, RSR_RESP_OKAY);
        axi_read(RSR_IDX_FSM_STATE, 32'h0D, M, RSR_RESP_OKAY);
        axi_read(RSR_IDX_PKT_STATUS, 32'h60, M, RSR_RESP_OKAY);
        // Every code; only on-off keying hides the offset
        for (int i = 0; i < 8; i++) begin
            radio.modulation <= rsr_mod_type'(i[2:0]);
            tick(2);
            axi_read(RSR_IDX_OFFSET, i == 3 ? 32'h0 : 32'h85, M,
                     RSR_RESP_OKAY);
        end
        axi_write(RSR_IDX_THRESHOLD, 32'h50, RSR_RESP_OKAY);
        tick(2);
        axi_read(RSR_IDX_PKT_STATUS, 32'h30, M, RSR_RESP_OKAY);
        axi_write(RSR_IDX_THRESHOLD, 32'h0, RSR_RESP_OKAY);
        axi_write(RSR_IDX_CHAN_CFG, 32'h0, RSR_RESP_OKAY);
        tick(2);
        axi_read(RSR_IDX_PKT_STATUS, 32'h70, M, RSR_RESP_OKAY);
        axi_write(RSR_IDX_OFFSET, 32'hFF, RSR_RESP_OKAY);
        axi_write(RSR_IDX_FSM_STATE, 32'h1, RSR_RESP_OKAY);
        axi_read(RSR_IDX_OFFSET, 32'h85, M, RSR_RESP_OKAY);
        axi_read(RSR_IDX_FSM_STATE, 32'h0D, M, RSR_RESP_OKAY);
        axi_write(16'hDF50, 32'h1, RSR_RESP_DECERR);
        axi_read(16'hDF50, 32'h0, M, RSR_RESP_DECERR);
        // Checksum event, interrupt, clear on read, clear on receive entry
        axi_write(RSR_IDX_IRQ_MASK, 32'h1, RSR_RESP_OKAY);
        radio.crc_done <= 1'b1;
        radio.crc_match <= 1'b1;
        tick(1);
        radio.crc_done <= 1'b0;
        tick(3);
        `CHK(irq, 1'b1)
        axi_read(RSR_IDX_LINK_QUALITY, 32'h80, 32'h80, RSR_RESP_OKAY);
        axi_read(RSR_IDX_PKT_STATUS, 32'h80, 32'h80, RSR_RESP_OKAY);
        axi_read(RSR_IDX_IRQ_STATUS, 32'h01, M, RSR_RESP_OKAY);
        tick(2);
        `CHK(irq, 1'b0)
        radio.radio_fsm_code <= RSR_ST_IDLE;
        tick(2);
        radio.radio_fsm_code <= RSR_ST_RX;
        tick(2);
        axi_read(RSR_IDX_LINK_QUALITY, 32'h0, 32'h80, RSR_RESP_OKAY);
        radio.radio_fsm_code <= RSR_ST_RX_OVERFLOW;
        tick(2);
        radio.radio_fsm_code <= RSR_ST_TX_UNDERFLOW;
        tick(2);
        axi_read(RSR_IDX_IRQ_STATUS, 32'h0C, 32'h0C, RSR_RESP_OKAY);
        // Quality 0..63 over exactly 64 symbols averages to 0x1F
        radio.frame_start_flag <= 1'b1;
        tick(1);
        for (int i = 0; i < 64; i++) begin
            radio.symbol_quality <= i[6:0];
            radio.symbol_tick <= 1'b1;
            tick(1);
            radio.symbol_tick <= 1'b0;
            tick(1);
        end
        tick(2);
        `CHK(irq, 1'b0)
        axi_read(RSR_IDX_LINK_QUALITY, 32'h1F, 32'h7F, RSR_RESP_OKAY);
        axi_read(RSR_IDX_IRQ_STATUS, 32'h12, 32'h12, RSR_RESP_OKAY);
        // Deep mode keeps the captured values
        pm <= RSR_PM_DEEP_A;
        tick(1);
        radio.signal_strength_field <= 8'h77;
        tick(2);
        `CHK(reg_on, 1'b0)
        axi_read(RSR_IDX_STRENGTH, 32'h40, M, RSR_RESP_OKAY);
        report_and_stop();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #25000;
        fails++;
        report_and_stop();
    end
endmodule : tb_radio_status_register_bank
